// ### src/rx_hash_dma.sv
// receive hash filter and receive-only slave dma engine
//
// Functional notes
// - crc of address, top six bits latched
// - index decoded one-hot against 64-bit table
// - table bit set gives hash-match flag
// - good hashed frame: good flag, index bits
// - normal event: extra, runt, crc, all-ones, own
// - erred frame clears hash flags; individual hash
// - all-ones exception needs exact table and controls
// - config bit nine moves every frame by dma
// - all-frames dma wins over auto-switch
// - channel value zero to two picks pins
// - start offset of latest frame in ring
// - twelve-bit frame count since last read
// - byte count since last read
// - ring size steers start offset wrap and the ring space check
// - request only after whole accepted frame
// - status word, length word, then data
// - duty limit: request on, then rest
// - after transfer: counters, done flag, interrupt
// - missed counter counts frames lost
// - event register reads zero in dma mode
// - second counter read releases committed space
// - done flag follows nonzero frame count
`timescale 1ns/1ps
module rx_hash_dma #(
  parameter int ON_CYCLES = rx_dma_pkg::BURST_ON_CYCLES,
  parameter int OFF_CYCLES = rx_dma_pkg::BURST_OFF_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic rx_sof_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_eof_i,
  input wire logic rx_crc_err_i,
  input wire logic rx_runt_i,
  input wire logic rx_extra_i,
  output logic [2:0] transfer_request_pin_o,
  input wire logic [2:0] transfer_acknowledge_pin_n_i,
  output logic [15:0] dma_data_o,
  output logic frame_done_irq_o
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [15:0] receive_config_reg, receive_control_reg;
  logic [15:0] buffer_config_reg, host_bus_control_reg;
  logic [1:0] dma_channel_select;
  logic [63:0] multicast_hash_table;
  logic [47:0] own_addr;
  logic [15:0] receive_event_reg, receive_frame_length;
  logic [15:0] dma_frame_start_offset, ring_ptr, dma_byte_counter;
  logic [rx_dma_pkg::FRAME_CNT_W-1:0] dma_frame_counter;
  logic [rx_dma_pkg::MISS_W-1:0] missed_frame_counter;
  logic [17:0] pend_bytes, commit_bytes;
  logic [5:0] crc_index_latch;
  logic [31:0] crc;
  logic [47:0] da;
  logic [10:0] rx_cnt;
  logic [7:0] low_byte;
  logic frame_full, dropping;
  logic wr_en;
  logic [rx_dma_pkg::RAM_AW-1:0] wr_addr;
  logic [15:0] wr_data, ram_q;
  logic [2:0] ack_s1, ack_s2, ack_s3;
  rx_dma_pkg::dma_state_e state;
  logic [10:0] widx;
  logic [31:0] duty_cnt;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // address decode shared by the write and read paths
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  // one byte through the reflected crc-32, lsb first as on the wire
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ rx_dma_pkg::CRC_POLY) : (r >> 1);
    end
    crc_byte = r;
  endfunction

  logic dma_mode, fc_rd, bc_rd, miss_rd, done, ack_fall;
  logic [10:0] last_widx;
  logic [15:0] adv, xfer_bytes;
  logic [17:0] ring_bytes, need;
  logic [31:0] next_crc;
  logic [63:0] hash_line;
  logic is_bcast, is_indiv, erred, own_match, table_hit, bcast_exc, hash_ok, accept;
  logic [15:0] next_event;

  // all-frames dma alone decides dma mode, so it wins over auto-switch
  assign dma_mode = receive_config_reg[rx_dma_pkg::CFG_DMA_ALL];
  assign fc_rd = reg_rd_i & hit(reg_addr_i, rx_dma_pkg::FRAME_CNT_OFS);
  assign bc_rd = reg_rd_i & hit(reg_addr_i, rx_dma_pkg::BYTE_CNT_OFS);
  assign miss_rd = reg_rd_i & hit(reg_addr_i, rx_dma_pkg::MISS_OFS);
  assign done = (state == rx_dma_pkg::DMA_DONE);
  assign next_crc = crc_byte(crc, rx_data_i);
  // words moved: status, length, then data rounded up to words
  assign last_widx = 11'(receive_frame_length[10:1] + receive_frame_length[0] + 11'd1);
  assign xfer_bytes = 16'({last_widx, 1'b0} + 12'd2);
  assign adv = (xfer_bytes + 16'd3) & 16'hFFFC; // dword aligned slot in ring
  assign ring_bytes = host_bus_control_reg[rx_dma_pkg::BUS_RING] ?
                      rx_dma_pkg::RING64_BYTES : rx_dma_pkg::RING16_BYTES;
  assign need = commit_bytes + pend_bytes + 18'(adv);
  // ack edge seen only on second and third flops of the synchroniser
  assign ack_fall = (dma_channel_select != 2'd3) & ack_s3[dma_channel_select]
                    & ~ack_s2[dma_channel_select];

  // ****************************************************************
  // hash and address filter
  // ****************************************************************
  // evaluated at end of frame from the latched address and index
  always_comb begin
    hash_line = 64'h1 << crc_index_latch;
    table_hit = |(hash_line & multicast_hash_table);
    is_bcast = &da;
    is_indiv = ~da[0];
    erred = rx_crc_err_i | rx_runt_i | rx_extra_i;
    own_match = (da == own_addr);
    bcast_exc = is_bcast & ~erred & (multicast_hash_table == rx_dma_pkg::ALL_ONES_TABLE)
                & receive_control_reg[rx_dma_pkg::CTL_OWN] & receive_control_reg[rx_dma_pkg::CTL_GROUP]
                & receive_control_reg[rx_dma_pkg::CTL_GOOD_ONLY] & receive_control_reg[rx_dma_pkg::CTL_INDIVIDUAL_HASH_FLAG]
                & receive_control_reg[rx_dma_pkg::CTL_ALL_ONES];
    hash_ok = ~erred & table_hit & ~is_bcast;
    next_event = {10'h000, rx_dma_pkg::EV_ID};
    if (hash_ok) begin
      next_event[15:10] = crc_index_latch;
      next_event[rx_dma_pkg::EV_INDIVIDUAL_HASH_FLAG] = is_indiv;
    end else begin
      next_event[14:10] = {rx_extra_i, rx_runt_i, rx_crc_err_i,
                           is_bcast & receive_control_reg[rx_dma_pkg::CTL_ALL_ONES],
                           own_match & receive_control_reg[rx_dma_pkg::CTL_OWN]};
    end
    next_event[rx_dma_pkg::EV_HASHED] = hash_ok | bcast_exc;
    next_event[rx_dma_pkg::EV_OK] = ~erred;
    accept = receive_control_reg[rx_dma_pkg::CTL_PROMISC]
             | (receive_control_reg[rx_dma_pkg::CTL_OWN] & own_match)
             | (receive_control_reg[rx_dma_pkg::CTL_INDIVIDUAL_HASH_FLAG] & is_indiv & table_hit)
             | (receive_control_reg[rx_dma_pkg::CTL_GROUP] & ~is_indiv & ~is_bcast & table_hit)
             | (receive_control_reg[rx_dma_pkg::CTL_ALL_ONES] & is_bcast) | bcast_exc;
    accept = accept & ~(receive_control_reg[rx_dma_pkg::CTL_GOOD_ONLY] & erred);
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  // software writes; an out-of-range channel value is ignored
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      receive_config_reg <= rx_dma_pkg::REG_RESET;
      receive_control_reg <= rx_dma_pkg::REG_RESET;
      buffer_config_reg <= rx_dma_pkg::REG_RESET;
      host_bus_control_reg <= rx_dma_pkg::REG_RESET;
      dma_channel_select <= rx_dma_pkg::CHANNEL_RESET;
      multicast_hash_table <= 64'h0;
      own_addr <= 48'h0;
    end else if (reg_wr_i) begin
      if (hit(reg_addr_i, rx_dma_pkg::RX_CFG_OFS)) begin
        receive_config_reg <= reg_wdata_i;
      end else if (hit(reg_addr_i, rx_dma_pkg::RX_CTL_OFS)) begin
        receive_control_reg <= reg_wdata_i;
      end else if (hit(reg_addr_i, rx_dma_pkg::BUF_CFG_OFS)) begin
        buffer_config_reg <= reg_wdata_i;
      end else if (hit(reg_addr_i, rx_dma_pkg::BUS_CTL_OFS)) begin
        host_bus_control_reg <= reg_wdata_i;
      end else if (hit(reg_addr_i, rx_dma_pkg::DMA_CHANNEL_OFS)) begin
        if (reg_wdata_i < 16'd3) begin
          dma_channel_select <= reg_wdata_i[1:0];
        end
      end else if (reg_addr_i[15:3] == rx_dma_pkg::HASH_TABLE_OFS[15:3]) begin
        multicast_hash_table[{reg_addr_i[2:1], 4'h0} +: 16] <= reg_wdata_i;
      end else if (reg_addr_i >= rx_dma_pkg::OWN_ADDR_OFS && reg_addr_i < rx_dma_pkg::OWN_ADDR_OFS + 16'd6) begin
        own_addr[{reg_addr_i[2:1], 4'h0} +: 16] <= reg_wdata_i;
      end
    end
  end

  // ****************************************************************
  // receive side: address capture, crc, buffering
  // ****************************************************************
  // one frame is held on chip until dma frees it; outside dma mode it is freed the next cycle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_cnt <= 11'h0;
      crc <= rx_dma_pkg::CRC_INIT;
      da <= 48'h0;
      low_byte <= 8'h0;
      crc_index_latch <= 6'h0;
      frame_full <= 1'b0;
      dropping <= 1'b1;
      wr_en <= 1'b0;
      wr_addr <= '0;
      wr_data <= 16'h0;
      receive_event_reg <= 16'h0;
      receive_frame_length <= 16'h0;
      missed_frame_counter <= '0;
    end else begin
      wr_en <= 1'b0;
      if (miss_rd) begin
        missed_frame_counter <= '0;
      end
      if (done || (frame_full && !dma_mode)) begin
        frame_full <= 1'b0;
      end
      if (rx_sof_i) begin
        rx_cnt <= 11'h0;
        crc <= rx_dma_pkg::CRC_INIT;
        dropping <= frame_full;
        if (frame_full) begin
          // a read of the counter in this cycle must not swallow the new loss
          missed_frame_counter <= (miss_rd ? '0 : missed_frame_counter) + 1'b1;
        end
      end else if (rx_valid_i && !dropping) begin
        rx_cnt <= rx_cnt + 11'd1;
        if (rx_cnt < 11'd6) begin
          da <= {rx_data_i, da[47:8]};
          crc <= next_crc;
        end
        if (rx_cnt == 11'd5) begin
          crc_index_latch <= {next_crc[0], next_crc[1], next_crc[2],
                              next_crc[3], next_crc[4], next_crc[5]};
        end
        if (rx_cnt[0]) begin
          wr_en <= 1'b1;
          wr_addr <= rx_cnt[10:1];
          wr_data <= {rx_data_i, low_byte};
        end else begin
          low_byte <= rx_data_i;
        end
        if (rx_cnt == 11'h7FF) begin
          dropping <= 1'b1; // too long for the on-chip buffer
          missed_frame_counter <= (miss_rd ? '0 : missed_frame_counter) + 1'b1;
        end
      end else if (rx_eof_i && !dropping) begin
        dropping <= 1'b1;
        if (rx_cnt[0]) begin
          wr_en <= 1'b1;
          wr_addr <= rx_cnt[10:1];
          wr_data <= {8'h00, low_byte};
        end
        receive_event_reg <= next_event;
        if (accept) begin
          frame_full <= 1'b1;
          receive_frame_length <= {5'h00, rx_cnt};
        end
      end
    end
  end

  frame_ram ram (
    .clock_i(clock_i),
    .wr_en_i(wr_en),
    .wr_addr_i(wr_addr),
    .wr_data_i(wr_data),
    .rd_addr_i(rx_dma_pkg::RAM_AW'(widx - 11'd2)),
    .rd_data_o(ram_q)
  );

  // ****************************************************************
  // acknowledge synchroniser
  // ****************************************************************
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ack_s1 <= 3'b111;
      ack_s2 <= 3'b111;
      ack_s3 <= 3'b111;
    end else begin
      ack_s1 <= transfer_acknowledge_pin_n_i;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
    end
  end

  // ****************************************************************
  // dma engine
  // ****************************************************************
  // waits for room in the ring beyond committed and pending space
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= rx_dma_pkg::DMA_IDLE;
      widx <= 11'h0;
      duty_cnt <= 32'h0;
      dma_data_o <= 16'h0;
    end else begin
      case (state)
        rx_dma_pkg::DMA_IDLE: begin
          widx <= 11'h0;
          duty_cnt <= 32'h0;
          if (frame_full && dma_mode && need <= ring_bytes) begin
            state <= rx_dma_pkg::DMA_MOVE;
          end
        end
        // an acknowledge already on its way when the rest starts is still served
        rx_dma_pkg::DMA_MOVE, rx_dma_pkg::DMA_REST: begin
          duty_cnt <= duty_cnt + 32'd1;
          if (ack_fall) begin
            widx <= widx + 11'd1;
            if (widx == 11'd0) begin
              dma_data_o <= receive_event_reg;
            end else if (widx == 11'd1) begin
              dma_data_o <= receive_frame_length;
            end else begin
              dma_data_o <= ram_q;
            end
            if (widx == last_widx) begin
              state <= rx_dma_pkg::DMA_DONE;
            end
          end else if (state == rx_dma_pkg::DMA_MOVE && host_bus_control_reg[rx_dma_pkg::BUS_DUTY]
                       && duty_cnt >= 32'(ON_CYCLES - 1)) begin
            state <= rx_dma_pkg::DMA_REST;
            duty_cnt <= 32'h0;
          end else if (state == rx_dma_pkg::DMA_REST && duty_cnt >= 32'(OFF_CYCLES - 1)) begin
            state <= rx_dma_pkg::DMA_MOVE;
            duty_cnt <= 32'h0;
          end
        end
        default: begin
          state <= rx_dma_pkg::DMA_IDLE;
        end
      endcase
    end
  end

  // request held while moving; a rest drops it
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      transfer_request_pin_o <= 3'b000;
    end else if (state == rx_dma_pkg::DMA_MOVE && dma_channel_select != 2'd3) begin
      transfer_request_pin_o <= 3'b001 << dma_channel_select;
    end else begin
      transfer_request_pin_o <= 3'b000;
    end
  end

  // ****************************************************************
  // completion counters and ring bookkeeping
  // ****************************************************************
  // a count read in the completing cycle keeps the new frame
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dma_frame_counter <= '0;
      dma_byte_counter <= 16'h0;
      dma_frame_start_offset <= 16'h0;
      ring_ptr <= 16'h0;
      pend_bytes <= 18'h0;
      commit_bytes <= 18'h0;
      frame_done_irq_o <= 1'b0;
    end else begin
      frame_done_irq_o <= done & buffer_config_reg[rx_dma_pkg::BUF_IRQ_EN];
      if (fc_rd) begin
        dma_frame_counter <= done ? 12'd1 : 12'd0;
      end else if (done) begin
        dma_frame_counter <= dma_frame_counter + 12'd1;
      end
      if (bc_rd) begin
        dma_byte_counter <= done ? xfer_bytes : 16'h0;
      end else if (done) begin
        dma_byte_counter <= dma_byte_counter + xfer_bytes;
      end
      // second read releases the old commitment and commits the new frames
      if (fc_rd) begin
        commit_bytes <= pend_bytes + (done ? 18'(adv) : 18'h0);
        pend_bytes <= 18'h0;
      end else if (done) begin
        pend_bytes <= pend_bytes + 18'(adv);
      end
      if (done) begin
        dma_frame_start_offset <= ring_ptr;
        if (host_bus_control_reg[rx_dma_pkg::BUS_RING]) begin
          ring_ptr <= ring_ptr + adv;
        end else begin
          ring_ptr <= (ring_ptr + adv) & rx_dma_pkg::RING16_MASK;
        end
      end
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0;
    end else if (reg_rd_i) begin
      if (hit(reg_addr_i, rx_dma_pkg::RX_EVENT_OFS)) begin
        reg_rdata_o <= dma_mode ? 16'h0000 : receive_event_reg;
      end else if (hit(reg_addr_i, rx_dma_pkg::BUF_EVENT_OFS)) begin
        reg_rdata_o <= {8'h00, dma_frame_counter != 12'd0, 1'b0, rx_dma_pkg::BUF_EV_ID};
      end else if (hit(reg_addr_i, rx_dma_pkg::FRAME_CNT_OFS)) begin
        reg_rdata_o <= {4'h0, dma_frame_counter};
      end else if (hit(reg_addr_i, rx_dma_pkg::BYTE_CNT_OFS)) begin
        reg_rdata_o <= dma_byte_counter;
      end else if (hit(reg_addr_i, rx_dma_pkg::START_OFS)) begin
        reg_rdata_o <= dma_frame_start_offset;
      end else if (hit(reg_addr_i, rx_dma_pkg::DMA_CHANNEL_OFS)) begin
        reg_rdata_o <= {14'h0, dma_channel_select};
      end else if (hit(reg_addr_i, rx_dma_pkg::MISS_OFS)) begin
        reg_rdata_o <= {missed_frame_counter, rx_dma_pkg::MISS_ID};
      end else if (hit(reg_addr_i, rx_dma_pkg::RX_CFG_OFS)) begin
        reg_rdata_o <= receive_config_reg;
      end else if (hit(reg_addr_i, rx_dma_pkg::RX_CTL_OFS)) begin
        reg_rdata_o <= receive_control_reg;
      end else if (hit(reg_addr_i, rx_dma_pkg::BUF_CFG_OFS)) begin
        reg_rdata_o <= buffer_config_reg;
      end else if (hit(reg_addr_i, rx_dma_pkg::BUS_CTL_OFS)) begin
        reg_rdata_o <= host_bus_control_reg;
      end else if (hit(reg_addr_i, rx_dma_pkg::FRAME_STATUS_OFS)) begin
        reg_rdata_o <= receive_event_reg;
      end else if (hit(reg_addr_i, rx_dma_pkg::FRAME_LENGTH_OFS)) begin
        reg_rdata_o <= receive_frame_length;
      end else if (reg_addr_i[15:3] == rx_dma_pkg::HASH_TABLE_OFS[15:3]) begin
        reg_rdata_o <= multicast_hash_table[{reg_addr_i[2:1], 4'h0} +: 16];
      end else begin
        reg_rdata_o <= 16'h0000; // unmapped reads as zero
      end
    end
  end
endmodule

// ### src/rx_dma_pkg.sv
// constants shared by the receive hash filter and receive dma block
package rx_dma_pkg;
  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [15:0] DMA_CHANNEL_OFS = 16'h0024;
  localparam logic [15:0] START_OFS = 16'h0026;
  localparam logic [15:0] FRAME_CNT_OFS = 16'h0028;
  localparam logic [15:0] BYTE_CNT_OFS = 16'h002A;
  localparam logic [15:0] RX_CFG_OFS = 16'h0102;
  localparam logic [15:0] RX_CTL_OFS = 16'h0104;
  localparam logic [15:0] BUF_CFG_OFS = 16'h0116;
  localparam logic [15:0] BUS_CTL_OFS = 16'h012E;
  localparam logic [15:0] RX_EVENT_OFS = 16'h0124;
  localparam logic [15:0] BUF_EVENT_OFS = 16'h0118;
  localparam logic [15:0] MISS_OFS = 16'h0130;
  localparam logic [15:0] HASH_TABLE_OFS = 16'h0150;
  localparam logic [15:0] OWN_ADDR_OFS = 16'h0158;
  localparam logic [15:0] FRAME_STATUS_OFS = 16'h0400;
  localparam logic [15:0] FRAME_LENGTH_OFS = 16'h0402;
  // ****************************************************************
  // field positions and identifiers
  // ****************************************************************
  localparam int CFG_DMA_ALL = 9;
  localparam int CFG_AUTO = 10;
  localparam int CTL_INDIVIDUAL_HASH_FLAG = 6;
  localparam int CTL_PROMISC = 7;
  localparam int CTL_GOOD_ONLY = 8;
  localparam int CTL_GROUP = 9;
  localparam int CTL_OWN = 10;
  localparam int CTL_ALL_ONES = 11;
  localparam int BUS_DUTY = 11;
  localparam int BUS_RING = 13;
  localparam int BUF_IRQ_EN = 7;
  localparam int BUF_DONE = 7;
  localparam int EV_HASHED = 9;
  localparam int EV_OK = 8;
  localparam int EV_INDIVIDUAL_HASH_FLAG = 6;
  localparam logic [5:0] EV_ID = 6'h04;
  localparam logic [5:0] BUF_EV_ID = 6'h0C;
  localparam logic [5:0] MISS_ID = 6'h10;
  localparam logic [63:0] ALL_ONES_TABLE = 64'h0000_8000_0000_0000;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  // ****************************************************************
  // sizes, reset values and timing
  // ****************************************************************
  localparam logic [17:0] RING16_BYTES = 18'h04000;
  localparam logic [17:0] RING64_BYTES = 18'h10000;
  localparam logic [15:0] RING16_MASK = 16'h3FFF;
  localparam int RAM_AW = 10;
  localparam int FRAME_CNT_W = 12;
  localparam int MISS_W = 10;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [1:0] CHANNEL_RESET = 2'h0;
  localparam int CLK_MHZ = 10;
  localparam int BURST_ON_US = 28000;
  localparam int BURST_OFF_US = 1300;
  localparam int BURST_ON_CYCLES = BURST_ON_US * CLK_MHZ;
  localparam int BURST_OFF_CYCLES = BURST_OFF_US * CLK_MHZ;
  typedef enum logic [1:0] {
    DMA_IDLE = 2'b00,
    DMA_MOVE = 2'b01,
    DMA_REST = 2'b10,
    DMA_DONE = 2'b11
  } dma_state_e;
endpackage

// ### src/frame_ram.sv
// on-chip frame buffer, one write port and a registered read port
`timescale 1ns/1ps
module frame_ram (
  input wire logic clock_i,
  input wire logic wr_en_i,
  input wire logic [rx_dma_pkg::RAM_AW-1:0] wr_addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [rx_dma_pkg::RAM_AW-1:0] rd_addr_i,
  output logic [15:0] rd_data_o
);
  logic [15:0] mem [0:(1<<rx_dma_pkg::RAM_AW)-1];

  // no reset on the array, contents are only read after being written
  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

// ### tb/rx_hash_dma_chk.sv
// port assertions for the receive hash filter and dma block
`timescale 1ns/1ps
module rx_hash_dma_chk #(parameter int ON_CYCLES = 40) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [2:0] transfer_request_pin_o,
  input wire logic frame_done_irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic dma_mode, irq_en, duty;
  logic [1:0] chan;
  int run;
  // shadow of the mode bits, and length of the current request run
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      {dma_mode, irq_en, duty, chan, run} <= '0;
    end else begin
      run <= (|transfer_request_pin_o) ? run + 1 : 0;
      if (reg_wr_i && reg_addr_i == 16'h0102) dma_mode <= reg_wdata_i[9];
      if (reg_wr_i && reg_addr_i == 16'h0116) irq_en <= reg_wdata_i[7];
      if (reg_wr_i && reg_addr_i == 16'h012E) duty <= reg_wdata_i[11];
      if (reg_wr_i && reg_addr_i == 16'h0024 && reg_wdata_i < 16'h0003) chan <= reg_wdata_i[1:0];
    end
  end
  one_pin_a: assert property ($onehot0(transfer_request_pin_o)) else $error("two pins");
  pin_choice_a: assert property ($rose(|transfer_request_pin_o) |->
    transfer_request_pin_o == 3'b001 << chan) else $error("wrong pin");
  dma_only_a: assert property (|transfer_request_pin_o |-> dma_mode) else $error("request off");
  event_zero_a: assert property (reg_rd_i && reg_addr_i == 16'h0124 && dma_mode
    |=> reg_rdata_o == 16'h0000) else $error("event nonzero");
  count_bits_a: assert property (reg_rd_i && reg_addr_i == 16'h0028
    |=> reg_rdata_o[15:12] == 4'h0) else $error("reserved set");
  irq_pulse_a: assert property (frame_done_irq_o |=> !frame_done_irq_o) else $error("irq long");
  irq_gate_a: assert property (frame_done_irq_o |-> irq_en) else $error("irq masked");
  duty_limit_a: assert property (duty |-> run < ON_CYCLES + 4) else $error("request long");
endmodule
bind rx_hash_dma rx_hash_dma_chk #(.ON_CYCLES(ON_CYCLES)) chk_u (.clock_i(clock_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .transfer_request_pin_o(transfer_request_pin_o),
  .frame_done_irq_o(frame_done_irq_o));

// ### tb/host_dma_model.sv
// host dma controller model: takes one word per acknowledge
`timescale 1ns/1ps
module host_dma_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [2:0] req_i,
  output logic [2:0] ack_n_o,
  input wire logic [15:0] data_i
);
  logic [15:0] w [0:63]; // ring base and its 128K check stay with host software
  int n = 0;
  // wide high gap keeps acknowledges legal and lets the data settle
  initial begin
    ack_n_o = 3'b111;
    forever begin
      @(posedge clock_i);
      if (!rst_i && |req_i) begin
        ack_n_o <= ~req_i;
        @(posedge clock_i) ack_n_o <= 3'b111;
        repeat (6) @(posedge clock_i);
        w[n] = data_i;
        n++;
      end
    end
  end
endmodule

// ### tb/testbench.sv
// self-checking bench for the receive hash filter and dma block
`timescale 1ns/1ps
module testbench;
  logic clock_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, sof = 1'b0, vld = 1'b0, eof = 1'b0, cerr = 1'b0, irq;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, dd, v;
  logic runt = 1'b0, xtra = 1'b0;
  logic [7:0] data = 8'h00;
  logic [2:0] req, ack_n;
  int error_cnt = 0, n_tests = 0;
  // 10 MHz clock
  always #50 clock_i = ~clock_i;
  rx_hash_dma #(.ON_CYCLES(40), .OFF_CYCLES(10)) dut_u (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .rx_sof_i(sof), .rx_valid_i(vld),
    .rx_data_i(data), .rx_eof_i(eof), .rx_crc_err_i(cerr), .rx_runt_i(runt), .rx_extra_i(xtra),
    .transfer_request_pin_o(req), .transfer_acknowledge_pin_n_i(ack_n), .dma_data_o(dd), .frame_done_irq_o(irq));
  host_dma_model host_u (.clock_i(clock_i), .rst_i(rst_i), .req_i(req), .ack_n_o(ack_n), .data_i(dd));
  // bus and stream tasks
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock_i) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clock_i) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [15:0] a);
    @(posedge clock_i) {addr, rd} <= {a, 1'b1};
    @(posedge clock_i) rd <= 1'b0;
    @(negedge clock_i) v = rdata;
  endtask
  // every byte of the frame is b, so the destination is b six times; e is extra, runt, crc error
  task automatic frame(input logic [7:0] b, input int len, input logic [2:0] e);
    @(posedge clock_i) sof <= 1'b1;
    repeat (len) @(posedge clock_i) {sof, vld, data} <= {2'b01, b};
    @(posedge clock_i) {vld, eof, xtra, runt, cerr} <= {2'b01, e};
    @(posedge clock_i) {eof, xtra, runt, cerr} <= 4'h0;
    repeat (3) @(posedge clock_i);
    rd_reg(16'h0124);
  endtask
  task automatic table_wr(input logic [63:0] t);
    for (int i = 0; i < 4; i++) wr_reg(16'h0150 + 16'(2 * i), t[16 * i +: 16]);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // filter events first, then two frames through the dma path
  initial begin
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    wr_reg(16'h0104, 16'h0280);
    frame(8'h01, 20, 3'h0);
    chk("event miss", 16'h0104, v & 16'h7F7F);
    table_wr({4{16'hFFFF}});
    frame(8'h01, 20, 3'h0);
    chk("event hashed", 16'h0304, v & 16'h037F);
    frame(8'h01, 20, 3'h5);
    chk("event erred", 16'h5004, v & 16'h7F7F);
    wr_reg(16'h0104, 16'h0F40);
    table_wr(rx_dma_pkg::ALL_ONES_TABLE);
    frame(8'hFF, 20, 3'h0);
    chk("event all ones", 16'h0B04, v & 16'h7F7F);
    wr_reg(16'h0024, 16'h0001);
    wr_reg(16'h0024, 16'h0003);
    rd_reg(16'h0024);
    chk("channel", 16'h0001, v);
    wr_reg(16'h0116, 16'h0080);
    wr_reg(16'h012E, 16'h0800);
    wr_reg(16'h0102, 16'h0200);
    frame(8'hFF, 60, 3'h0);
    chk("event in dma", 16'h0000, v);
    // lands while the first frame still holds the on-chip buffer, so it is lost
    frame(8'h01, 8, 3'h0);
    for (int i = 0; i < 5000 && irq !== 1'b1; i++) @(negedge clock_i);
    chk("irq", 16'h0001, {15'h0000, irq});
    chk("status word", 16'h0B04, host_u.w[0] & 16'h7F7F);
    chk("length word", 16'h003C, host_u.w[1]);
    chk("first data", 16'hFFFF, host_u.w[2]);
    rd_reg(16'h002A);
    chk("byte count", 16'h0040, v);
    rd_reg(16'h0130);
    chk("missed", 16'h0050, v);
    frame(8'hFF, 8, 3'h0);
    for (int i = 0; i < 5000 && irq !== 1'b1; i++) @(negedge clock_i);
    chk("irq again", 16'h0001, {15'h0000, irq});
    rd_reg(16'h0026);
    chk("start offset", 16'h0040, v);
    rd_reg(16'h0118);
    rd_reg(16'h0118);
    chk("done held", 16'h0080, v & 16'h0080);
    rd_reg(16'h0028);
    chk("frame count", 16'h0002, v);
    rd_reg(16'h0028);
    chk("count cleared", 16'h0000, v);
    rd_reg(16'h0118);
    chk("done cleared", 16'h0000, v & 16'h0080);
    end_of_test();
  end
endmodule
